/* shared/svw_pkg.sv */
// Package for the supervisor watchdog and chip-enable gate.
// Assumes a single core clock at the rate named here; all times are counted
// in ticks of an internal time base derived from that clock.
package svw_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and time base
    localparam int CORE_CLK_MHZ = 200;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = CORE_CLK_MHZ * TICK_US;

    ////////////////////////////////////////////////////////////////////////
    // Documented times, in their own units
    localparam int WDOG_PERIOD_MS = 1600;
    localparam int RESET_TIMEOUT_MS = 200;
    localparam int WRITE_ALLOW_US = 18;
    localparam int US_PER_MS = 1000;

    // Counts in time-base ticks; the watchdog and reset timeout are exact
    // multiples of the tick, the write allowance rounds down (a longest time)
    localparam int WDOG_TICKS = (WDOG_PERIOD_MS * US_PER_MS) / TICK_US;
    localparam int RESET_TICKS = (RESET_TIMEOUT_MS * US_PER_MS) / TICK_US;
    localparam int WRITE_ALLOW_TICKS_RAW = WRITE_ALLOW_US / TICK_US;
    localparam int WRITE_ALLOW_TICKS = (WRITE_ALLOW_TICKS_RAW < 1) ? 1 : WRITE_ALLOW_TICKS_RAW;

    ////////////////////////////////////////////////////////////////////////
    // Reset values of the pin-facing flip-flops, and the forced-high chip-enable level
    localparam logic RST_ACTIVE_INIT = 1'h1;
    localparam logic CE_OUT_N_INIT = 1'h1;
    localparam logic CE_HIGH = 1'h1;

    ////////////////////////////////////////////////////////////////////////
    // Chip-enable gate states
    typedef enum logic [1:0] {
        SVW_CE_OFF   = 2'b00,
        SVW_CE_PASS  = 2'b01,
        SVW_CE_GRACE = 2'b10
    } svw_ce_state_e;

    // Chip-enable output pin group
    typedef struct packed {
        logic out_n;       // Level on the chip-enable output
        logic pullup_on;   // Output actively held high, gate off
        logic in_hiz;      // Chip-enable input disconnected
    } svw_ce_s;

endpackage

/* logic/svw_tick_gen.sv */
// Free-running time-base tick generator.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module svw_tick_gen #(
    parameter int CYCLES = 200
) (
    input wire logic core_clk,
    input wire logic rst,
    output logic tick
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_ff;
    wire at_last = (cnt_ff == LAST);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= at_last ? '0 : cnt_ff + 1'b1;
        end
    end

    assign tick = at_last;
endmodule
`default_nettype wire

/* logic/svw_tick_counter.sv */
// Saturating tick counter with synchronous clear and a reached flag.
// Assumes the tick input is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
`default_nettype none
module svw_tick_counter #(
    parameter int LIMIT = 18
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic tick,
    output logic [$clog2(LIMIT+1)-1:0] count,
    output logic done
);
    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LIM = W'(LIMIT);

    logic [W-1:0] cnt_ff;

    // Clear wins over counting so a held clear keeps the count at zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (clear) begin
            cnt_ff <= '0;
        end else if (tick && !done) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign done = (cnt_ff == LIM);
    assign count = cnt_ff;
endmodule
`default_nettype wire

/* logic/svw_supervisor.sv */
// Supervisor core: watchdog, reset timing and chip-enable gating.
// Assumes all inputs are synchronous to core_clk; the comparator inputs come
// from analog circuitry outside this block.
//
// Overview of operation
// [RULE_01] Watchdog input idle for 1.6 s outside reset forces a full reset.
// [RULE_02] Watchdog timer clears on reset and on any input edge outside reset.
// [RULE_03] Watchdog timer holds at zero in reset, counts right after release.
// [RULE_04] A floating watchdog input disables the watchdog timeout.
// [RULE_05] With reset released and backup mode off, the gate passes every chip-enable transition.
// [RULE_06] Reset disables the chip-enable path, apart from the write allowance.
// [RULE_07] Supply fail during a write keeps the gate on up to 18 us.
// [RULE_08] Chip-enable still low at allowance end: gate off, output high.
// [RULE_09] Chip-enable returning high within allowance: gate off, output high then.
// [RULE_10] After turning off, output stays high even if chip-enable falls again.
// [RULE_11] At power-up the chip-enable input is ignored until reset releases.
// [RULE_12] A disabled gate drives its output high; released when gate enables.
// [RULE_13] Backup mode ignores the watchdog input completely.
// [RULE_14] Backup mode holds the chip-enable output high.
// [RULE_15] Processor should toggle watchdog at separate program points, not pulse.
// [RULE_16] Active-low reset is held for at least the 200 ms timeout.
// [RULE_17] Supply-low during the timeout restarts the timeout from zero.
// [RULE_18] Reset is asserted while the supply is below the threshold.
// [RULE_19] Active-high reset is always the inverse of active-low reset.
// [RULE_20] All three times are counted in time-base ticks with parameter counts.
`timescale 1ns/100ps
`default_nettype none
module svw_supervisor #(
    parameter int WDOG_COUNT = svw_pkg::WDOG_TICKS,
    parameter int RESET_COUNT = svw_pkg::RESET_TICKS,
    parameter int WRITE_COUNT = svw_pkg::WRITE_ALLOW_TICKS,
    parameter int TICK_COUNT = svw_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reset_threshold_level,
    input wire logic supply_warning_det,
    input wire logic backup_supply,
    input wire logic watchdog_toggle_in,
    input wire logic watchdog_toggle_valid,
    input wire logic ce_in_n,
    output logic reset_n,
    output logic reset_hi,
    output logic supply_warning_n,
    output svw_pkg::svw_ce_s ce_gate
);
    import svw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Time base

    logic tick;

    svw_tick_gen #(
        .CYCLES(TICK_COUNT)
    ) u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic reset_active_ff;
    logic reset_n_ff;
    logic reset_hi_ff;
    logic warn_n_ff;
    logic toggle_prev_ff;
    svw_ce_state_e ce_state_ff;
    svw_ce_s ce_gate_ff;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog

    logic wdog_clear;
    logic wdog_done;
    logic [$clog2(WDOG_COUNT+1)-1:0] wdog_count;

    // Backup mode and a mid-supply input both keep the timer parked at zero
    wire toggle_edge = (watchdog_toggle_in != toggle_prev_ff);
    wire wdog_kick = toggle_edge && !reset_active_ff; // RULE_02
    wire wdog_off = !watchdog_toggle_valid || backup_supply; // RULE_04 RULE_13
    assign wdog_clear = reset_active_ff || wdog_kick || wdog_off; // RULE_02 RULE_03
    wire wdog_fire = wdog_done && !reset_active_ff && !wdog_off; // RULE_01

    svw_tick_counter #(
        .LIMIT(WDOG_COUNT)
    ) u_wdog ( // RULE_20
        .core_clk(core_clk),
        .rst(rst),
        .clear(wdog_clear),
        .tick(tick),
        .count(wdog_count),
        .done(wdog_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reset timeout

    logic rto_done;
    logic [$clog2(RESET_COUNT+2)-1:0] rto_count;

    // Supply-low keeps the timeout at zero, so a dip restarts the full period
    wire rto_clear = !reset_active_ff || reset_threshold_level; // RULE_17

    // One spare tick: the free-running tick may fall just after the clear,
    // so a bare count could release reset up to one tick early
    svw_tick_counter #(
        .LIMIT(RESET_COUNT + 1)
    ) u_rto ( // RULE_20 RULE_16
        .core_clk(core_clk),
        .rst(rst),
        .clear(rto_clear),
        .tick(tick),
        .count(rto_count),
        .done(rto_done)
    );

    wire reset_hold = reset_active_ff && !rto_done; // RULE_16
    wire nxt_reset_active = reset_threshold_level || wdog_fire || reset_hold; // RULE_18 RULE_01

    ////////////////////////////////////////////////////////////////////////
    // Write-completion allowance

    logic grace_done;

    svw_tick_counter #(
        .LIMIT(WRITE_COUNT)
    ) u_grace ( // RULE_20
        .core_clk(core_clk),
        .rst(rst),
        .clear(ce_state_ff != SVW_CE_GRACE),
        .tick(tick),
        .count(),
        .done(grace_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Chip-enable gate

    svw_ce_state_e nxt_ce_state;

    always_comb begin
        nxt_ce_state = ce_state_ff;
        case (ce_state_ff)
            SVW_CE_OFF: begin
                // Power-up and recovery: input stays ignored until reset ends
                if (!reset_active_ff && !backup_supply) begin // RULE_11
                    nxt_ce_state = SVW_CE_PASS;
                end
            end
            SVW_CE_PASS: begin
                if (backup_supply) begin
                    nxt_ce_state = SVW_CE_OFF; // RULE_14
                end else if (reset_active_ff) begin
                    nxt_ce_state = ce_in_n ? SVW_CE_OFF : SVW_CE_GRACE; // RULE_06 RULE_07
                end
            end
            SVW_CE_GRACE: begin
                if (backup_supply || ce_in_n) begin
                    nxt_ce_state = SVW_CE_OFF; // RULE_09
                end else if (grace_done) begin
                    nxt_ce_state = SVW_CE_OFF; // RULE_08
                end
            end
            default: begin
                nxt_ce_state = SVW_CE_OFF;
            end
        endcase
    end

    wire gate_on = (nxt_ce_state == SVW_CE_PASS) || (nxt_ce_state == SVW_CE_GRACE);
    // The output costs one register stage; a transmission gate has none
    wire nxt_ce_out_n = gate_on ? ce_in_n : CE_HIGH; // RULE_05 RULE_10 RULE_12
    svw_ce_s nxt_ce_gate;
    assign nxt_ce_gate = '{out_n: nxt_ce_out_n, pullup_on: !gate_on, in_hiz: !gate_on};

    ////////////////////////////////////////////////////////////////////////
    // Flip-flops

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reset_active_ff <= RST_ACTIVE_INIT;
            reset_n_ff <= !RST_ACTIVE_INIT;
            reset_hi_ff <= RST_ACTIVE_INIT;
            warn_n_ff <= !RST_ACTIVE_INIT;
            toggle_prev_ff <= 1'h0;
            ce_state_ff <= SVW_CE_OFF;
            ce_gate_ff <= '{out_n: CE_OUT_N_INIT, pullup_on: 1'h1, in_hiz: 1'h1};
        end else begin
            reset_active_ff <= nxt_reset_active;
            reset_n_ff <= !nxt_reset_active;
            reset_hi_ff <= nxt_reset_active; // RULE_19
            warn_n_ff <= !(supply_warning_det || backup_supply);
            toggle_prev_ff <= watchdog_toggle_in;
            ce_state_ff <= nxt_ce_state;
            ce_gate_ff <= nxt_ce_gate;
        end
    end

    assign reset_n = reset_n_ff;
    assign reset_hi = reset_hi_ff;
    assign supply_warning_n = warn_n_ff;
    assign ce_gate = ce_gate_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_reset_inverse;
        @(posedge core_clk) disable iff (rst)
        reset_hi_ff == !reset_n_ff;
    endproperty
    a_reset_inverse: assert property (p_reset_inverse) // RULE_19
        else $error("active-high reset not inverse of active-low reset");

    property p_supply_low_resets;
        @(posedge core_clk) disable iff (rst)
        reset_threshold_level |=> !reset_n_ff;
    endproperty
    a_supply_low_resets: assert property (p_supply_low_resets) // RULE_18
        else $error("reset not asserted while supply below threshold");

    property p_timeout_restart;
        @(posedge core_clk) disable iff (rst)
        reset_threshold_level |=> (rto_count == '0) && reset_active_ff;
    endproperty
    a_timeout_restart: assert property (p_timeout_restart) // RULE_17
        else $error("reset timeout not restarted by supply low");

    property p_release_after_timeout;
        @(posedge core_clk) disable iff (rst)
        $rose(reset_n_ff) |-> $past(rto_done) && !$past(reset_threshold_level);
    endproperty
    a_release_after_timeout: assert property (p_release_after_timeout) // RULE_16
        else $error("reset released before timeout completed");

    property p_wdog_fires;
        @(posedge core_clk) disable iff (rst)
        wdog_done && !reset_active_ff && watchdog_toggle_valid && !backup_supply
            |=> reset_active_ff && !reset_n_ff;
    endproperty
    a_wdog_fires: assert property (p_wdog_fires) // RULE_01
        else $error("watchdog expiry did not assert reset");

    property p_wdog_held_in_reset;
        @(posedge core_clk) disable iff (rst)
        reset_active_ff |=> wdog_count == '0;
    endproperty
    a_wdog_held_in_reset: assert property (p_wdog_held_in_reset) // RULE_03
        else $error("watchdog counted during reset");

    property p_edge_clears;
        @(posedge core_clk) disable iff (rst)
        (watchdog_toggle_in != $past(watchdog_toggle_in)) && !reset_active_ff
            |=> wdog_count == '0;
    endproperty
    a_edge_clears: assert property (p_edge_clears) // RULE_02
        else $error("watchdog edge did not clear timer");

    property p_float_disables;
        @(posedge core_clk) disable iff (rst)
        !watchdog_toggle_valid || backup_supply |=> (wdog_count == '0) && !wdog_fire;
    endproperty
    a_float_disables: assert property (p_float_disables) // RULE_04 RULE_13
        else $error("watchdog active while floating or in backup");

    property p_backup_high;
        @(posedge core_clk) disable iff (rst)
        backup_supply |=> ce_gate_ff.out_n && ce_gate_ff.pullup_on;
    endproperty
    a_backup_high: assert property (p_backup_high) // RULE_14
        else $error("chip-enable output not high in backup mode");

    property p_pass_through;
        @(posedge core_clk) disable iff (rst)
        (ce_state_ff == SVW_CE_PASS) && !reset_active_ff && !backup_supply
            |=> ce_gate_ff.out_n == $past(ce_in_n) && !ce_gate_ff.pullup_on;
    endproperty
    a_pass_through: assert property (p_pass_through) // RULE_05
        else $error("enabled gate did not pass chip-enable");

    property p_grace_release;
        @(posedge core_clk) disable iff (rst)
        (ce_state_ff == SVW_CE_GRACE) && ce_in_n
            |=> (ce_state_ff == SVW_CE_OFF) && ce_gate_ff.out_n;
    endproperty
    a_grace_release: assert property (p_grace_release) // RULE_09
        else $error("gate stayed on after write finished");

    property p_grace_expire;
        @(posedge core_clk) disable iff (rst)
        (ce_state_ff == SVW_CE_GRACE) && grace_done |=> ce_gate_ff.out_n;
    endproperty
    a_grace_expire: assert property (p_grace_expire) // RULE_08 RULE_07
        else $error("gate stayed on past write allowance");

    property p_off_stays_high;
        @(posedge core_clk) disable iff (rst)
        (ce_state_ff == SVW_CE_OFF) && reset_active_ff [*2]
            |-> ce_gate_ff.out_n && ce_gate_ff.pullup_on && ce_gate_ff.in_hiz;
    endproperty
    a_off_stays_high: assert property (p_off_stays_high) // RULE_10 RULE_11 RULE_12 RULE_06
        else $error("disabled gate output not held high");

    c_wdog_timeout: cover property (@(posedge core_clk) disable iff (rst) wdog_fire);
    c_grace_entry: cover property (@(posedge core_clk) disable iff (rst)
        ce_state_ff == SVW_CE_PASS ##1 ce_state_ff == SVW_CE_GRACE);
    c_grace_expired: cover property (@(posedge core_clk) disable iff (rst)
        (ce_state_ff == SVW_CE_GRACE) && grace_done);
    c_release: cover property (@(posedge core_clk) disable iff (rst) $rose(reset_n_ff));

endmodule
`default_nettype wire

/* tb/svw_cpu_model.sv */
// Processor model: watchdog toggle level and RAM chip-enable request.
// Assumes the bench changes its controls just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module svw_cpu_model (
    input wire logic core_clk,
    input wire logic keep_alive,
    input wire logic [7:0] gap,
    input wire logic float_pin,
    input wire logic ce_req,
    output logic watchdog_toggle_in,
    output logic watchdog_toggle_valid,
    output logic ce_in_n
);
    logic level = 1'h0;
    logic [7:0] idle = 8'h00;
    assign watchdog_toggle_valid = ~float_pin;
    assign ce_in_n = ~ce_req;
    initial watchdog_toggle_in = 1'h0;
    ////////////////////////////////////////////////////////////////////////
    // Level set at separate program points rather than pulsed, so a stuck
    // loop stops the toggling; a released pin shows its inverted last level
    // Reads the controls a little after the bench writes them, so no race
    always @(posedge core_clk) begin
        #2;
        if (keep_alive && !float_pin && idle >= gap) begin
            level = ~level;
            idle = 8'h00;
        end else begin
            idle = idle + 8'h01;
        end
        watchdog_toggle_in = float_pin ? ~level : level;
    end
endmodule
`default_nettype wire

/* tb/svw_supervisor_bench.sv */
// Testbench for the supervisor: reset timing, watchdog and chip-enable gate.
// Assumes short simulation counts and the processor model on the far side.
`timescale 1ns/100ps
`default_nettype none
module svw_supervisor_bench;
    import svw_pkg::*;
    localparam int T = 2;
    localparam int R = 10;
    localparam int W = 40;
    localparam int WR = 3;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic thr = 1'h1;
    logic det = 1'h0;
    logic backup = 1'h0;
    logic keep_alive = 1'h1;
    logic float_pin = 1'h0;
    logic ce_req = 1'h0;
    logic [31:0] r;
    wire logic wd_in;
    wire logic wd_valid;
    wire logic ce_in_n;
    logic reset_n;
    logic reset_hi;
    logic swn;
    svw_ce_s ce_gate;
    wire logic [5:0] obs;
    logic [5:0] notes[$];
    logic [5:0] e;
    int n_errors = 0;
    int tests_run = 0;
    int n;
    event look;
    assign obs = {reset_n, reset_hi, swn, ce_gate};
    svw_supervisor #(.WDOG_COUNT(W), .RESET_COUNT(R), .WRITE_COUNT(WR), .TICK_COUNT(T)) dut (
        .core_clk(core_clk), .rst(rst), .reset_threshold_level(thr),
        .supply_warning_det(det), .backup_supply(backup), .watchdog_toggle_in(wd_in),
        .watchdog_toggle_valid(wd_valid), .ce_in_n(ce_in_n), .reset_n(reset_n),
        .reset_hi(reset_hi), .supply_warning_n(swn), .ce_gate(ce_gate)
    );
    svw_cpu_model cpu (
        .core_clk(core_clk), .keep_alive(keep_alive), .gap(8'h14), .float_pin(float_pin),
        .ce_req(ce_req), .watchdog_toggle_in(wd_in), .watchdog_toggle_valid(wd_valid),
        .ce_in_n(ce_in_n)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // Expected pin state; the monitor compares it once the outputs settle
    task automatic note(input logic rn, input logic sw, input logic on, input logic off);
        notes.push_back({rn, ~rn, sw, on, off, off});
        -> look;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic span(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    // Cycles until one output bit reaches a level; a hang ends the run
    task automatic wait_obs(input int i, input logic lvl, input int lim, output int k);
        k = 0;
        while (obs[i] !== lvl) begin
            step(1);
            k++;
            if (k > lim) begin
                n_errors++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, obs[i], lvl);
                give_verdict();
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        forever begin
            @(look);
            while (notes.size() > 0) begin
                e = notes.pop_front();
                tests_run++;
                if (obs !== e) begin
                    n_errors++;
                    $display("CHECK FAILED at %0t: got %h expected %h", $time, obs, e);
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32'h8ACF);
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'h0;
        // Chip-enable activity while the supply is low must never reach the RAM
        repeat (12) begin
            r = $urandom;
            ce_req = r[0];
            step(1);
            note(1'h0, 1'h1, 1'h1, 1'h1);
        end
        ce_req = 1'h0;
        thr = 1'h0;
        wait_obs(5, 1'h1, R * T + 10, n);
        span(n, (R - 1) * T, R * T + 4);
        $display("test power_up over");
        thr = 1'h1;
        step(2);
        note(1'h0, 1'h1, 1'h1, 1'h1);
        thr = 1'h0;
        step(R * T / 2);
        thr = 1'h1;
        step(1);
        thr = 1'h0;
        wait_obs(5, 1'h1, R * T + 10, n);
        span(n, (R - 1) * T, R * T + 4);
        $display("test restart over");
        step(2);
        repeat (40) begin
            r = $urandom;
            ce_req = r[0];
            det = r[1];
            step(1);
            note(1'h1, ~det, ~ce_req, 1'h0);
        end
        det = 1'h0;
        ce_req = 1'h0;
        step(300);
        note(1'h1, 1'h1, 1'h1, 1'h0);
        $display("test pass_through over");
        // Silent processor: the watchdog must count only from reset release
        keep_alive = 1'h0;
        thr = 1'h1;
        step(1);
        thr = 1'h0;
        wait_obs(5, 1'h1, R * T + 10, n);
        wait_obs(5, 1'h0, W * T + 10, n);
        span(n, (W - 1) * T, W * T + 4);
        wait_obs(5, 1'h1, R * T + 10, n);
        span(n, (R - 1) * T, R * T + 4);
        // Checked while a timer that ignored the pin would be holding reset
        float_pin = 1'h1;
        step(W * T + R * T / 2);
        note(1'h1, 1'h1, 1'h1, 1'h0);
        $display("test watchdog over");
        // Backup with the supply fine: a stalled processor must not cause a reset
        float_pin = 1'h0;
        backup = 1'h1;
        step(W * T + R * T / 2);
        note(1'h1, 1'h0, 1'h1, 1'h1);
        keep_alive = 1'h1;
        backup = 1'h1;
        thr = 1'h1;
        step(2);
        ce_req = 1'h1;
        step(2);
        note(1'h0, 1'h0, 1'h1, 1'h1);
        float_pin = 1'h0;
        backup = 1'h0;
        ce_req = 1'h0;
        thr = 1'h0;
        wait_obs(5, 1'h1, R * T + 10, n);
        $display("test backup over");
        // Write in progress when the supply fails, held past the allowance
        step(2);
        ce_req = 1'h1;
        step(2);
        note(1'h1, 1'h1, 1'h0, 1'h0);
        thr = 1'h1;
        wait_obs(2, 1'h1, WR * T + 10, n);
        span(n, (WR - 1) * T, WR * T + 5);
        ce_req = 1'h0;
        step(2);
        ce_req = 1'h1;
        step(3);
        note(1'h0, 1'h1, 1'h1, 1'h1);
        ce_req = 1'h0;
        thr = 1'h0;
        wait_obs(5, 1'h1, R * T + 10, n);
        // Write that ends inside the allowance
        step(2);
        ce_req = 1'h1;
        step(1);
        thr = 1'h1;
        step(3);
        note(1'h0, 1'h1, 1'h0, 1'h0);
        ce_req = 1'h0;
        wait_obs(2, 1'h1, 4, n);
        span(n, 1, 1);
        ce_req = 1'h1;
        step(2);
        note(1'h0, 1'h1, 1'h1, 1'h1);
        ce_req = 1'h0;
        thr = 1'h0;
        wait_obs(5, 1'h1, R * T + 10, n);
        step(2);
        thr = 1'h1;
        step(2);
        ce_req = 1'h1;
        step(2);
        note(1'h0, 1'h1, 1'h1, 1'h1);
        $display("test write_allowance over");
        give_verdict();
    end
endmodule
`default_nettype wire
